// File: rtl/cap_timer_defines.svh
// Register indices, field positions, reset values and counts
`ifndef CAP_TIMER_DEFINES_SVH
`define CAP_TIMER_DEFINES_SVH

// =====================================
// Register indices (byte address = 4 * index)
`define IDX_TIMER_CTRL   8'hC8
`define IDX_TIMER_MODE   8'hC9
`define IDX_CMP_LOW      8'hCA
`define IDX_CMP_HIGH     8'hCB
`define IDX_CNT_LOW      8'hCC
`define IDX_CNT_HIGH     8'hCD
`define IDX_CAP_EN_FLAGS 8'h92
`define IDX_CAP_EDGE     8'h93
`define IDX_CAP_FILT     8'h94
`define IDX_RES0_LOW     8'hE4
`define IDX_RES0_HIGH    8'hE5
`define IDX_RES1_LOW     8'hE6
`define IDX_RES1_HIGH    8'hE7
`define IDX_RES2_LOW     8'hED
`define IDX_RES2_HIGH    8'hEE
`define IDX_PIN_SEL01    8'hF1
`define IDX_PIN_SEL2     8'hF2
`define IDX_IRQ_STATUS   8'hA0
`define IDX_IRQ_MASK     8'hA1
`define IDX_IRQ_CTRL     8'hA2

// =====================================
// Field positions
`define TCTRL_FLAG     7
`define TCTRL_RUN      2
`define TCTRL_CMP_MODE 0
`define MODE_RELOAD_EN 7
`define MODE_CAP_CLR   3
`define MODE_CMP_CLR   2
`define CAP_EN_LSB     4
`define FILT_EN_LSB    4
`define IRQ_CTRL_CAP   0
`define IRQ_CTRL_GLOB  7
`define STAT_CMP       3

// =====================================
// Reset values, responses and counts
`define REG_RESET     8'h00
`define CNT_ZERO      16'h0000
`define CNT_MAX       16'hFFFF
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`define FILTER_CYCLES 4
`define NUM_PINS      9

`endif

// File: rtl/cap_timer_pkg.sv
// Types shared by the timer capture/compare block
package cap_timer_pkg;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_RSVD = 2'b11
  } edge_sel_t;

  typedef struct packed {
    logic       acc;
    logic       prev;
    logic [1:0] cnt;
  } filt_state_t;

  typedef struct packed {
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic              aw_full, w_full, wstrb0;
    logic [11:0]       aw_addr;
    logic [7:0]        wdata;
    logic              cmp_mode, run, tf;
    logic              reload_en, cap_clr, cmp_clr;
    logic [1:0]        trig;
    logic [15:0]       cmp_val, cnt;
    logic [2:0]        cap_en, cap_flag, filt_en;
    logic [5:0]        edge_sel;
    logic [2:0][15:0]  result;
    logic [2:0][3:0]   pin_sel;
    logic [3:0]        irq_mask;
    logic              cap_ie, gie, irq;
    logic [8:0]        sync1, sync2, sync3, pin_lvl;
  } top_state_t;

endpackage : cap_timer_pkg

// File: rtl/cap_chan_if.sv
// Signals between the top block and one capture channel
`timescale 1ns/100ps
interface cap_chan_if;
  import cap_timer_pkg::*;
  logic      level;
  logic      filt_en;
  logic      enable;
  edge_sel_t edge_sel;
  logic      hit;
  modport chan (input level, filt_en, enable, edge_sel, output hit);
  modport ctrl (output level, filt_en, enable, edge_sel, input hit);
endinterface : cap_chan_if

// File: rtl/cap_edge_filter.sv
// One capture channel: glitch filter and edge detector
`timescale 1ns/100ps
`include "cap_timer_defines.svh"
module cap_edge_filter (
  input wire logic clk,
  input wire logic rst_n,
  cap_chan_if.chan port
);
  import cap_timer_pkg::*;

  localparam logic [1:0] LAST = 2'(`FILTER_CYCLES - 1);

  filt_state_t q, d;

  function automatic logic edge_match(edge_sel_t sel, logic prv, logic cur);
    case (sel)
      EDGE_FALL: edge_match = prv & ~cur;
      EDGE_RISE: edge_match = ~prv & cur;
      EDGE_BOTH: edge_match = prv ^ cur;
      default:   edge_match = 1'b0;
    endcase
  endfunction : edge_match

  always_comb begin
    d = q;
    d.prev = q.acc;
    // (R5) Reject short pulses
    if (!port.filt_en) begin
      d.acc = port.level;
      d.cnt = 2'b00;
    end else if (port.level == q.acc) begin
      d.cnt = 2'b00;
    end else if (q.cnt == LAST) begin
      d.acc = port.level;
      d.cnt = 2'b00;
    end else begin
      d.cnt = q.cnt + 2'b01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // (R8) Edge select decode
  assign port.hit = port.enable & edge_match(port.edge_sel, q.prev, q.acc);

  a_filter_stable: assert property (@(posedge clk) disable iff (!rst_n) // (R5)
    $changed(q.acc) && $past(port.filt_en) |->
      $past(port.level, 1) == q.acc && $past(port.level, 2) == q.acc &&
      $past(port.level, 3) == q.acc && $past(port.level, 4) == q.acc)
    else $error("filtered level changed before four stable cycles");

endmodule : cap_edge_filter

// File: rtl/cap_timer.sv
// Timer compare and three-channel input capture with AXI4-Lite registers
`timescale 1ns/100ps
`include "cap_timer_defines.svh"

// Notes on behaviour
// (R1) Compare mode uses reload pair as compare
// (R2) Counter equals compare sets timer flag
// (R3) Compare auto-clear zeroes counter after match
// (R4) Three channels pick from nine pins
// (R5) Enabled filter rejects pulses under four clocks
// (R6) Filter enables at bits 6:4
// (R7) Own edge detector, shared counter
// (R8) Edge select: fall, rise, either, reserved
// (R9) Channel captures only when enabled
// (R10) Edge copies counter into result bytes
// (R11) Edge sets channel flag bit n
// (R12) Flag with both enables requests interrupt; the code also needs the flag's irq_mask bit set
// (R13) Flags stay until software clears them
// (R14) Capture auto-clear zeroes counter after capture
// (R15) Results readable and writable as bytes
// (R16) Capture registers reset to zero
// (R17) Reload trigger: overflow or capture channel
// (R18) Capture clear replaces reload, not both
// (R19) Hardware set beats same-cycle software clear
module cap_timer #(
  parameter int ADDR_W = 12
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic [8:0]        CAPTURE_PINS,
  output logic                   IRQ
);
  import cap_timer_pkg::*;

  top_state_t s_q, s_d;
  wire  [2:0] cap_evt;
  logic       wr_fire, cnt_wr;
  logic [7:0] wr_idx, wr_data;
  logic       cmp_hit, ovf, cap_clr_hit, reload_hit;
  logic [3:0] trig_src;

  // ==========================================
  // Helpers
  function automatic logic is_mapped(input logic [11:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[11:10] != 2'b00) begin
      is_mapped = 1'b0;
    end else begin
      case (idx)
        `IDX_TIMER_CTRL, `IDX_TIMER_MODE, `IDX_CMP_LOW, `IDX_CMP_HIGH,
        `IDX_CNT_LOW, `IDX_CNT_HIGH, `IDX_CAP_EN_FLAGS, `IDX_CAP_EDGE,
        `IDX_CAP_FILT, `IDX_RES0_LOW, `IDX_RES0_HIGH, `IDX_RES1_LOW,
        `IDX_RES1_HIGH, `IDX_RES2_LOW, `IDX_RES2_HIGH, `IDX_PIN_SEL01,
        `IDX_PIN_SEL2, `IDX_IRQ_STATUS, `IDX_IRQ_MASK,
        `IDX_IRQ_CTRL: is_mapped = 1'b1;
        default:       is_mapped = 1'b0;
      endcase
    end
  endfunction : is_mapped

  function automatic logic pin_pick(input logic [8:0] pins, input logic [3:0] sel);
    pin_pick = (sel < 4'(`NUM_PINS)) ? pins[sel] : pins[0];
  endfunction : pin_pick

  function automatic logic [7:0] rd_value(input top_state_t s, input logic [7:0] idx);
    logic [7:0] v;
    v = `REG_RESET;
    case (idx)
      `IDX_TIMER_CTRL: begin
        v[`TCTRL_FLAG]     = s.tf;
        v[`TCTRL_RUN]      = s.run;
        v[`TCTRL_CMP_MODE] = s.cmp_mode;
      end
      `IDX_TIMER_MODE: begin
        v[`MODE_RELOAD_EN] = s.reload_en;
        v[`MODE_CAP_CLR]   = s.cap_clr;
        v[`MODE_CMP_CLR]   = s.cmp_clr;
        v[1:0]             = s.trig;
      end
      `IDX_CMP_LOW:      v = s.cmp_val[7:0];
      `IDX_CMP_HIGH:     v = s.cmp_val[15:8];
      `IDX_CNT_LOW:      v = s.cnt[7:0];
      `IDX_CNT_HIGH:     v = s.cnt[15:8];
      `IDX_CAP_EN_FLAGS: v = {1'b0, s.cap_en, 1'b0, s.cap_flag};
      `IDX_CAP_EDGE:     v = {2'b00, s.edge_sel};
      `IDX_CAP_FILT:     v = {1'b0, s.filt_en, 4'h0};
      // (R15) Result bytes
      `IDX_RES0_LOW:     v = s.result[0][7:0];
      `IDX_RES0_HIGH:    v = s.result[0][15:8];
      `IDX_RES1_LOW:     v = s.result[1][7:0];
      `IDX_RES1_HIGH:    v = s.result[1][15:8];
      `IDX_RES2_LOW:     v = s.result[2][7:0];
      `IDX_RES2_HIGH:    v = s.result[2][15:8];
      `IDX_PIN_SEL01:    v = {s.pin_sel[1], s.pin_sel[0]};
      `IDX_PIN_SEL2:     v = {4'h0, s.pin_sel[2]};
      `IDX_IRQ_STATUS:   v = {4'h0, s.tf, s.cap_flag};
      `IDX_IRQ_MASK:     v = {4'h0, s.irq_mask};
      `IDX_IRQ_CTRL: begin
        v[`IRQ_CTRL_CAP]  = s.cap_ie;
        v[`IRQ_CTRL_GLOB] = s.gie;
      end
      default:           v = `REG_RESET;
    endcase
    rd_value = v;
  endfunction : rd_value

  // ==========================================
  // Capture channels
  // (R7) One detector per channel
  for (genvar i = 0; i < 3; i++) begin : g_ch
    cap_chan_if cif ();
    // (R4) Pin multiplexer
    assign cif.level    = pin_pick(s_q.pin_lvl, s_q.pin_sel[i]);
    // (R6) Filter enable field
    assign cif.filt_en  = s_q.filt_en[i];
    // (R9) Channel enable gate
    assign cif.enable   = s_q.cap_en[i];
    assign cif.edge_sel = edge_sel_t'(s_q.edge_sel[2*i +: 2]);
    assign cap_evt[i]   = cif.hit;
    cap_edge_filter u_ch (
      .clk   (CLK),
      .rst_n (RESETN),
      .port  (cif.chan)
    );
  end

  // ==========================================
  // Event decode
  assign wr_fire = s_q.aw_full & s_q.w_full & ~s_q.bvalid & s_q.wstrb0 &
                   is_mapped(s_q.aw_addr);
  assign wr_idx  = s_q.aw_addr[9:2];
  assign wr_data = s_q.wdata;
  assign cnt_wr  = wr_fire & (wr_idx == `IDX_CNT_LOW || wr_idx == `IDX_CNT_HIGH);
  // (R1) Compare value is the reload pair
  // (R2) Match while counting in compare mode
  assign cmp_hit = s_q.cmp_mode & s_q.run & (s_q.cnt == s_q.cmp_val);
  assign ovf     = ~s_q.cmp_mode & s_q.run & (s_q.cnt == `CNT_MAX);
  assign cap_clr_hit = s_q.cap_clr & (|cap_evt);
  // (R17) Reload trigger select
  assign trig_src   = {cap_evt, ovf};
  assign reload_hit = ~s_q.cmp_mode & s_q.reload_en & trig_src[s_q.trig];

  // ==========================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.sync1   = CAPTURE_PINS;
    s_d.sync2   = s_q.sync1;
    s_d.sync3   = s_q.sync2;
    s_d.pin_lvl = (s_q.sync2 & s_q.sync3) | (s_q.pin_lvl & (s_q.sync2 ^ s_q.sync3));

    if (wr_fire) begin
      case (wr_idx)
        `IDX_TIMER_CTRL: begin
          s_d.cmp_mode = wr_data[`TCTRL_CMP_MODE];
          s_d.run      = wr_data[`TCTRL_RUN];
          if (wr_data[`TCTRL_FLAG]) begin
            s_d.tf = 1'b0;
          end
        end
        `IDX_TIMER_MODE: begin
          s_d.reload_en = wr_data[`MODE_RELOAD_EN];
          s_d.cap_clr   = wr_data[`MODE_CAP_CLR];
          s_d.cmp_clr   = wr_data[`MODE_CMP_CLR];
          s_d.trig      = wr_data[1:0];
        end
        `IDX_CMP_LOW:  s_d.cmp_val[7:0]  = wr_data;
        `IDX_CMP_HIGH: s_d.cmp_val[15:8] = wr_data;
        // (R13) Software clears flags
        `IDX_CAP_EN_FLAGS: begin
          s_d.cap_en   = wr_data[`CAP_EN_LSB +: 3];
          s_d.cap_flag = s_q.cap_flag & ~wr_data[2:0];
        end
        `IDX_CAP_EDGE: s_d.edge_sel = wr_data[5:0];
        `IDX_CAP_FILT: s_d.filt_en  = wr_data[`FILT_EN_LSB +: 3];
        // (R15) Software writes results
        `IDX_RES0_LOW:  s_d.result[0][7:0]  = wr_data;
        `IDX_RES0_HIGH: s_d.result[0][15:8] = wr_data;
        `IDX_RES1_LOW:  s_d.result[1][7:0]  = wr_data;
        `IDX_RES1_HIGH: s_d.result[1][15:8] = wr_data;
        `IDX_RES2_LOW:  s_d.result[2][7:0]  = wr_data;
        `IDX_RES2_HIGH: s_d.result[2][15:8] = wr_data;
        `IDX_PIN_SEL01: begin
          s_d.pin_sel[0] = wr_data[3:0];
          s_d.pin_sel[1] = wr_data[7:4];
        end
        `IDX_PIN_SEL2: s_d.pin_sel[2] = wr_data[3:0];
        `IDX_IRQ_STATUS: begin
          s_d.cap_flag = s_q.cap_flag & ~wr_data[2:0];
          if (wr_data[`STAT_CMP]) begin
            s_d.tf = 1'b0;
          end
        end
        `IDX_IRQ_MASK: s_d.irq_mask = wr_data[3:0];
        `IDX_IRQ_CTRL: begin
          s_d.cap_ie = wr_data[`IRQ_CTRL_CAP];
          s_d.gie    = wr_data[`IRQ_CTRL_GLOB];
        end
        default: ;
      endcase
    end

    // Counter
    if (s_q.run) begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    // (R14) (R18) Capture clear wins over reload
    if (cap_clr_hit) begin
      s_d.cnt = `CNT_ZERO;
    // (R3) Clear on compare match
    end else if (cmp_hit && s_q.cmp_clr) begin
      s_d.cnt = `CNT_ZERO;
    end else if (reload_hit) begin
      s_d.cnt = s_q.cmp_val;
    end
    if (wr_fire && wr_idx == `IDX_CNT_LOW) begin
      s_d.cnt[7:0] = wr_data;
    end
    if (wr_fire && wr_idx == `IDX_CNT_HIGH) begin
      s_d.cnt[15:8] = wr_data;
    end

    // (R10) (R11) (R19) Capture after software so set wins
    for (int i = 0; i < 3; i++) begin
      if (cap_evt[i]) begin
        s_d.result[i]   = s_q.cnt;
        s_d.cap_flag[i] = 1'b1;
      end
    end
    // (R2) Timer flag on match or overflow
    if (cmp_hit || ovf) begin
      s_d.tf = 1'b1;
    end
    // (R12) Shared interrupt request
    s_d.irq = s_d.gie & ((s_d.cap_ie & |(s_d.cap_flag & s_d.irq_mask[2:0])) |
                         (s_d.irq_mask[`STAT_CMP] & s_d.tf));

    // AXI write channel
    if (s_q.awready && AWVALID) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = AWADDR[11:0];
    end
    if (s_q.wready && WVALID) begin
      s_d.w_full = 1'b1;
      s_d.wdata  = WDATA[7:0];
      s_d.wstrb0 = WSTRB[0];
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = is_mapped(s_q.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = ~s_d.aw_full & ~s_d.bvalid;
    s_d.wready  = ~s_d.w_full & ~s_d.bvalid;

    // AXI read channel
    if (s_q.arready && ARVALID) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = {24'h00_0000, rd_value(s_q, ARADDR[9:2])};
      s_d.rresp  = is_mapped(ARADDR[11:0]) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = ~s_d.rvalid;
  end

  // (R16) All registers clear at reset
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign AWREADY = s_q.awready;
  assign WREADY  = s_q.wready;
  assign BVALID  = s_q.bvalid;
  assign BRESP   = s_q.bresp;
  assign ARREADY = s_q.arready;
  assign RVALID  = s_q.rvalid;
  assign RDATA   = s_q.rdata;
  assign RRESP   = s_q.rresp;
  assign IRQ     = s_q.irq;

  // ==========================================
  // Assertions
  a_cmp_flag_set: assert property (@(posedge CLK) disable iff (!RESETN) // (R2)
    cmp_hit |=> s_q.tf)
    else $error("compare match did not set timer flag");

  a_cmp_auto_clear: assert property (@(posedge CLK) disable iff (!RESETN) // (R3)
    cmp_hit && s_q.cmp_clr && !cnt_wr |=> s_q.cnt == `CNT_ZERO)
    else $error("compare match did not clear counter");

  a_cmp_keep_count: assert property (@(posedge CLK) disable iff (!RESETN) // (R3)
    cmp_hit && !s_q.cmp_clr && !cap_clr_hit && !cnt_wr |=>
      s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("counter did not continue after match");

  a_cap_snapshot: assert property (@(posedge CLK) disable iff (!RESETN) // (R10)
    cap_evt[0] |=> s_q.result[0] == $past(s_q.cnt))
    else $error("capture result differs from counter");

  a_cap_flag_set: assert property (@(posedge CLK) disable iff (!RESETN) // (R19)
    cap_evt[1] |=> s_q.cap_flag[1])
    else $error("capture event lost its flag");

  a_flag_sticky: assert property (@(posedge CLK) disable iff (!RESETN) // (R13)
    s_q.cap_flag[2] && !wr_fire |=> s_q.cap_flag[2])
    else $error("capture flag dropped without software");

  a_irq_request: assert property (@(posedge CLK) disable iff (!RESETN) // (R12)
    s_q.gie && s_q.cap_ie && |(s_q.cap_flag & s_q.irq_mask[2:0]) && !wr_fire
      |=> IRQ)
    else $error("interrupt not requested");

  a_irq_global_off: assert property (@(posedge CLK) disable iff (!RESETN) // (R12)
    !s_q.gie && !wr_fire |=> !IRQ)
    else $error("interrupt raised while globally disabled");

  a_cap_auto_clear: assert property (@(posedge CLK) disable iff (!RESETN) // (R14)
    cap_clr_hit && !cnt_wr |=> s_q.cnt == `CNT_ZERO)
    else $error("capture did not clear counter");

  a_clear_not_load: assert property (@(posedge CLK) disable iff (!RESETN) // (R18)
    reload_hit && s_q.trig != 2'b00 && s_q.cap_clr && !cnt_wr |=>
      s_q.cnt == `CNT_ZERO)
    else $error("reload applied instead of capture clear");

  a_reload_ovf: assert property (@(posedge CLK) disable iff (!RESETN) // (R17)
    ovf && s_q.reload_en && s_q.trig == 2'b00 && !cap_clr_hit && !cnt_wr |=>
      s_q.cnt == $past(s_q.cmp_val))
    else $error("overflow reload missing");

  a_disabled_quiet: assert property (@(posedge CLK) disable iff (!RESETN) // (R9)
    !s_q.cap_en[2] |-> !cap_evt[2])
    else $error("disabled channel produced capture");

endmodule : cap_timer

// File: dv/pin_source.sv
// External signal source for the capture pins
`timescale 1ns/100ps
module pin_source (
  input wire logic       clk,
  output logic     [8:0] pins
);
  // =====================================
  // Idle low until a test moves a pin
  initial begin
    pins = 9'h000;
  end

  // Move one pin, then let the capture path settle
  task automatic set_pin(input int n, input logic v);
    @(posedge clk);
    pins[n] <= v;
    repeat (12) @(posedge clk);
  endtask : set_pin

  // High pulse of w clock cycles
  task automatic pulse(input int n, input int w);
    @(posedge clk);
    pins[n] <= 1'b1;
    repeat (w) @(posedge clk);
    pins[n] <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : pulse
endmodule : pin_source

// File: dv/testbench.sv
// Self-checking bench for the timer capture/compare block
`timescale 1ns/100ps
`include "cap_timer_defines.svh"
module testbench;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] ex;
  } row_t;

  logic        CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic [11:0] AWADDR = '0;
  logic        AWVALID = 1'b0;
  logic        AWREADY;
  logic [31:0] WDATA = '0;
  logic [3:0]  WSTRB = '0;
  logic        WVALID = 1'b0;
  logic        WREADY;
  logic [1:0]  BRESP;
  logic        BVALID;
  logic        BREADY = 1'b0;
  logic [11:0] ARADDR = '0;
  logic        ARVALID = 1'b0;
  logic        ARREADY;
  logic [31:0] RDATA;
  logic [1:0]  RRESP;
  logic        RVALID;
  logic        RREADY = 1'b0;
  logic [8:0]  pins;
  logic        IRQ;
  int          miscompares = 0;
  int          total_checks = 0;
  row_t        rows [0:6] = '{'{8'hE4, 8'hA5, 8'hA5}, '{8'hE5, 8'h5A, 8'h5A},
                              '{8'hE6, 8'h3C, 8'h3C}, '{8'hE7, 8'hC3, 8'hC3},
                              '{8'h93, 8'h3F, 8'h3F}, '{8'h94, 8'h70, 8'h70},
                              '{8'h92, 8'h70, 8'h70}};

  always #12.5 CLK = ~CLK;

  cap_timer i_cap_timer (.CLK(CLK), .RESETN(RESETN), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .CAPTURE_PINS(pins), .IRQ(IRQ));
  pin_source i_pin_source (.clk(CLK), .pins(pins));

  // =====================================
  // Compare and report
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit

  task automatic hang;
    miscompares++;
    $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    wrap_up();
  endtask : hang

  // =====================================
  // AXI4-Lite master
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er = `RESP_OKAY);
    int   n;
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge CLK);
    AWADDR <= {2'b00, idx, 2'b00};
    WDATA <= {24'h0000_00, d};
    WSTRB <= 4'h1;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (!aw && AWREADY === 1'b1) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
      if (aw && w && BVALID === 1'b1) break;
    end
    if (n == 50) hang();
    BREADY <= 1'b0;
    chk_byte({6'h00, BRESP}, {6'h00, er});
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    int   n;
    logic a;
    a = 1'b0;
    @(posedge CLK);
    ARADDR <= {2'b00, idx, 2'b00};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (!a && ARREADY === 1'b1) begin
        a = 1'b1;
        ARVALID <= 1'b0;
      end
      if (a && RVALID === 1'b1) break;
    end
    if (n == 50) hang();
    RREADY <= 1'b0;
    chk_byte(RDATA[7:0], e);
    chk_byte({6'h00, RRESP}, {6'h00, er});
  endtask : rd

  task automatic irq_is(input logic e);
    repeat (2) @(posedge CLK);
    chk_bit(IRQ, e);
  endtask : irq_is

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  // =====================================
  // Main sequence
  initial begin
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (2) @(posedge CLK);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].idx, rows[i].wd, `RESP_OKAY);
      rd(rows[i].idx, rows[i].ex, `RESP_OKAY);
    end
    done("rows");
    wr(8'h00, 8'h55, `RESP_SLVERR);
    rd(8'h00, 8'h00, `RESP_SLVERR);
    done("unmapped");
    // Stopped counter gives a known capture value
    wr(`IDX_CAP_EN_FLAGS, 8'h17);
    wr(`IDX_CAP_EDGE, 8'h01);
    wr(`IDX_CAP_FILT, 8'h00);
    wr(`IDX_CNT_LOW, 8'h34);
    wr(`IDX_CNT_HIGH, 8'h12);
    wr(`IDX_TIMER_MODE, 8'h08);
    i_pin_source.pulse(0, 6);
    rd(`IDX_RES0_LOW, 8'h34, `RESP_OKAY);
    rd(`IDX_RES0_HIGH, 8'h12, `RESP_OKAY);
    rd(`IDX_CNT_LOW, 8'h00, `RESP_OKAY);
    rd(`IDX_CNT_HIGH, 8'h00, `RESP_OKAY);
    rd(`IDX_CAP_EN_FLAGS, 8'h11, `RESP_OKAY);
    rd(`IDX_CAP_EN_FLAGS, 8'h11, `RESP_OKAY);
    done("capture");
    irq_is(1'b0);
    wr(`IDX_IRQ_CTRL, 8'h81);
    wr(`IDX_IRQ_MASK, 8'h07);
    irq_is(1'b1);
    wr(`IDX_IRQ_MASK, 8'h00);
    irq_is(1'b0);
    wr(`IDX_IRQ_MASK, 8'h07);
    wr(`IDX_IRQ_CTRL, 8'h01);
    irq_is(1'b0);
    wr(`IDX_IRQ_CTRL, 8'h81);
    irq_is(1'b1);
    wr(`IDX_CAP_EN_FLAGS, 8'h11);
    irq_is(1'b0);
    rd(`IDX_CAP_EN_FLAGS, 8'h10, `RESP_OKAY);
    done("irq");
    wr(`IDX_CAP_FILT, 8'h10);
    i_pin_source.pulse(0, 3);
    rd(`IDX_CAP_EN_FLAGS, 8'h10, `RESP_OKAY);
    i_pin_source.pulse(0, 8);
    rd(`IDX_CAP_EN_FLAGS, 8'h11, `RESP_OKAY);
    done("filter");
    // Channel 1 and disabled channel 2 share pin 1
    wr(`IDX_CAP_FILT, 8'h00);
    wr(`IDX_PIN_SEL01, 8'h10);
    wr(`IDX_PIN_SEL2, 8'h01);
    wr(`IDX_CAP_EN_FLAGS, 8'h27);
    for (int e = 0; e < 4; e++) begin
      wr(`IDX_CAP_EDGE, 8'(e << 2));
      i_pin_source.set_pin(1, 1'b1);
      rd(`IDX_CAP_EN_FLAGS, {6'h08, e == 1 || e == 2, 1'b0}, `RESP_OKAY);
      wr(`IDX_CAP_EN_FLAGS, 8'h27);
      i_pin_source.set_pin(1, 1'b0);
      rd(`IDX_CAP_EN_FLAGS, {6'h08, e == 0 || e == 2, 1'b0}, `RESP_OKAY);
      wr(`IDX_CAP_EN_FLAGS, 8'h27);
    end
    done("edges");
    wr(`IDX_TIMER_MODE, 8'h04);
    wr(`IDX_CMP_LOW, 8'h10);
    wr(`IDX_CMP_HIGH, 8'h00);
    wr(`IDX_CNT_LOW, 8'h00);
    wr(`IDX_CNT_HIGH, 8'h00);
    wr(`IDX_TIMER_CTRL, 8'h05);
    repeat (300) @(posedge CLK);
    wr(`IDX_TIMER_CTRL, 8'h01);
    rd(`IDX_CNT_HIGH, 8'h00, `RESP_OKAY);
    rd(`IDX_TIMER_CTRL, 8'h81, `RESP_OKAY);
    wr(`IDX_TIMER_MODE, 8'h00);
    wr(`IDX_TIMER_CTRL, 8'h85);
    repeat (300) @(posedge CLK);
    wr(`IDX_TIMER_CTRL, 8'h01);
    rd(`IDX_CNT_HIGH, 8'h01, `RESP_OKAY);
    rd(`IDX_TIMER_CTRL, 8'h81, `RESP_OKAY);
    done("compare");
    // Overflow reloads the counter from the reload pair
    wr(`IDX_CMP_LOW, 8'hF0);
    wr(`IDX_CMP_HIGH, 8'hFF);
    wr(`IDX_CNT_LOW, 8'hF0);
    wr(`IDX_CNT_HIGH, 8'hFF);
    wr(`IDX_TIMER_MODE, 8'h80);
    wr(`IDX_TIMER_CTRL, 8'h84);
    repeat (40) @(posedge CLK);
    wr(`IDX_TIMER_CTRL, 8'h00);
    rd(`IDX_CNT_HIGH, 8'hFF, `RESP_OKAY);
    rd(`IDX_IRQ_STATUS, 8'h08, `RESP_OKAY);
    wr(`IDX_IRQ_MASK, 8'h08);
    irq_is(1'b1);
    wr(`IDX_IRQ_STATUS, 8'h08);
    irq_is(1'b0);
    done("reload");
    // Capture clear wins over a capture-triggered reload
    wr(`IDX_TIMER_MODE, 8'h8B);
    wr(`IDX_CAP_EDGE, 8'h10);
    wr(`IDX_CAP_EN_FLAGS, 8'h47);
    wr(`IDX_CNT_LOW, 8'h78);
    wr(`IDX_CNT_HIGH, 8'h56);
    i_pin_source.set_pin(1, 1'b1);
    rd(`IDX_RES2_LOW, 8'h78, `RESP_OKAY);
    rd(`IDX_RES2_HIGH, 8'h56, `RESP_OKAY);
    rd(`IDX_CNT_HIGH, 8'h00, `RESP_OKAY);
    rd(`IDX_CAP_EN_FLAGS, 8'h44, `RESP_OKAY);
    done("clear");
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (2) @(posedge CLK);
    chk_bit(IRQ, 1'b0);
    for (int i = 0; i < 7; i++) begin
      rd(rows[i].idx, 8'h00, `RESP_OKAY);
    end
    done("reset");
    wrap_up();
  end
endmodule : testbench
